//--- usrt_pkg.sv
// Shared constants and types for the serial port receiver and master transmitter.
package usrt_pkg;

    // Register offsets on the byte-wide register port.
    localparam logic [7:0] OFS_IRQ_CONTROL = 8'h0B;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_RX_STATUS = 8'h18;
    localparam logic [7:0] OFS_TX_BUFFER = 8'h19;
    localparam logic [7:0] OFS_RX_BUFFER = 8'h1A;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h8C;
    localparam logic [7:0] OFS_TX_STATUS = 8'h98;
    localparam logic [7:0] OFS_BAUD = 8'h99;

    // Receive status and control fields.
    localparam int RX_PORT_EN_BIT = 7;
    localparam int RX_NINE_SEL_BIT = 6;
    localparam int RX_SINGLE_BIT = 5;
    localparam int RX_CONT_BIT = 4;
    localparam int RX_FRAME_ERR_BIT = 2;
    localparam int RX_OVERRUN_BIT = 1;
    localparam int RX_NINTH_BIT = 0;

    // Transmit status and control fields.
    localparam int TX_CLK_MASTER_BIT = 7;
    localparam int TX_NINE_SEL_BIT = 6;
    localparam int TX_ENABLE_BIT = 5;
    localparam int TX_SYNC_SEL_BIT = 4;
    localparam int TX_HIGH_SPEED_BIT = 2;
    localparam int TX_SHIFT_EMPTY_BIT = 1;
    localparam int TX_NINTH_BIT = 0;

    // Peripheral flag fields.
    localparam int FLAG_RX_BIT = 5;
    localparam int FLAG_TX_BIT = 4;

    // Reset values.
    localparam logic [7:0] RX_STATUS_RESET = 8'h00;
    localparam logic [7:0] TX_STATUS_RESET = 8'h02;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;

    // Oversampling counts for the asynchronous receiver.
    localparam logic [3:0] RX_MID_TICK = 4'h7;
    localparam logic [3:0] RX_LAST_TICK = 4'hF;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } usrt_rxstate_e;

    typedef struct packed {
        logic frameErr;
        logic ninth;
        logic [7:0] data;
    } usrt_rxword_s;

endpackage

//--- usrt_core.sv
// Async receiver and synchronous master transmitter of a serial port.
//
// Notes on behaviour
// RQ1: Line sampled by a sixteen-times clock; main shifter moves at bit rate.
// RQ2: Asynchronous reception only while continuous receive enable is set.
// RQ3: After stop bit, shift register moves to FIFO if room; flag set.
// RQ4: Receive flag read-only; clears once buffer read and empty.
// RQ5: Receive buffer is a two-deep FIFO read twice to empty.
// RQ6: Stop bit with FIFO full sets overrun and drops the word.
// RQ7: Overrun clears by dropping continuous enable; blocks FIFO transfers.
// RQ8: Stop bit sampled low sets framing error for that word.
// RQ9: Framing error and ninth bit queue with data; read advances them.
// RQ10: Software reads status before data or loses the status bits.
// RQ11: Software sets baud, mode, nine-bit, then continuous enable.
// RQ12: Synchronous master is half duplex; receive inhibits transmit.
// RQ13: Sync select enters sync mode; port enable claims clock and data pins.
// RQ14: Clock source bit selects master; device drives the shift clock.
// RQ15: Shift register reloads after last bit; flag set, cleared by write.
// RQ16: Shift-empty status is read-only, set while shift register empty.
// RQ17: First bit goes out on rising clock; data stable at falling edge.
// RQ18: Baud generator held reset while all enables clear; starts at once.
// RQ19: Clearing transmit enable aborts, resets transmitter, floats both pins; the code keeps the clock pin driven while a receive enable is set.
// RQ20: Receive enable aborts transmit, floats data, clock stays driven.
// RQ21: Single receive enable clears after one word; transmit then resumes.
// RQ22: Ninth transmit bit captured at transfer; software writes it first.
// RQ23: Frame is start bit, eight or nine data bits LSB first, stop bit.
// RQ24: Bit rate is clock over 64, 16 or 4 times divisor plus one.
// RQ25: Start found on falling line edge; bits sampled mid period.
`timescale 1ns/1ps

module usrt_core
    import usrt_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Clock pin of the serial port.
    input wire logic clkPinIn,
    output logic clkPinOut,
    output logic clkPinOe,
    // Data pin of the serial port.
    input wire logic dataPinIn,
    output logic dataPinOut,
    output logic dataPinOe,
    // Word-done pulse from the synchronous receiver outside this block.
    input wire logic syncRxWordDone
);

    ////////////////////////////////////////////////////////////////////////
    // Registers written by software.

    logic portEn_r, rxNine_r, rxSingle_r, rxCont_r;
    logic clkMaster_r, txNine_r, transmit_enable_r, syncSel_r, highSpeed_r, txNinth_r;
    logic [7:0] baud_r, irqEnable_r, irqControl_r;
    logic wrRxStatus, wrTxStatus, wrTxBuf, rdRxBuf;

    assign wrRxStatus = regWrite && regAddr == OFS_RX_STATUS;
    assign wrTxStatus = regWrite && regAddr == OFS_TX_STATUS;
    assign wrTxBuf = regWrite && regAddr == OFS_TX_BUFFER;
    assign rdRxBuf = regRead && regAddr == OFS_RX_BUFFER;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portEn_r <= RX_STATUS_RESET[RX_PORT_EN_BIT];
            rxNine_r <= RX_STATUS_RESET[RX_NINE_SEL_BIT];
            rxCont_r <= RX_STATUS_RESET[RX_CONT_BIT];
        end else if (wrRxStatus) begin
            portEn_r <= regWrData[RX_PORT_EN_BIT];
            rxNine_r <= regWrData[RX_NINE_SEL_BIT];
            rxCont_r <= regWrData[RX_CONT_BIT];
        end
    end

    // The receiver outside signals the end of its single word.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxSingle_r <= RX_STATUS_RESET[RX_SINGLE_BIT];
        end else if (syncRxWordDone && syncSel_r && rxSingle_r) begin
            rxSingle_r <= 1'b0; // RQ21
        end else if (wrRxStatus) begin
            rxSingle_r <= regWrData[RX_SINGLE_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clkMaster_r <= TX_STATUS_RESET[TX_CLK_MASTER_BIT];
            txNine_r <= TX_STATUS_RESET[TX_NINE_SEL_BIT];
            transmit_enable_r <= TX_STATUS_RESET[TX_ENABLE_BIT];
            syncSel_r <= TX_STATUS_RESET[TX_SYNC_SEL_BIT];
            highSpeed_r <= TX_STATUS_RESET[TX_HIGH_SPEED_BIT];
            txNinth_r <= TX_STATUS_RESET[TX_NINTH_BIT];
        end else if (wrTxStatus) begin
            clkMaster_r <= regWrData[TX_CLK_MASTER_BIT];
            txNine_r <= regWrData[TX_NINE_SEL_BIT];
            transmit_enable_r <= regWrData[TX_ENABLE_BIT];
            syncSel_r <= regWrData[TX_SYNC_SEL_BIT];
            highSpeed_r <= regWrData[TX_HIGH_SPEED_BIT];
            txNinth_r <= regWrData[TX_NINTH_BIT];
        end
    end

    // Interrupt enable and control bytes are plain storage here.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            baud_r <= BAUD_RESET;
            irqEnable_r <= IRQ_ENABLE_RESET;
            irqControl_r <= IRQ_CONTROL_RESET;
        end else if (regWrite) begin
            if (regAddr == OFS_BAUD) begin
                baud_r <= regWrData;
            end
            if (regAddr == OFS_IRQ_ENABLE) begin
                irqEnable_r <= regWrData;
            end
            if (regAddr == OFS_IRQ_CONTROL) begin
                irqControl_r <= regWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser for the data pin only; the clock pin input is not used in this block.

    logic [1:0] dataSync_r;
    logic rxLine, rxLinePrev_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataSync_r <= 2'b11;
            rxLinePrev_r <= 1'b1;
        end else begin
            dataSync_r <= {dataSync_r[0], dataPinIn};
            rxLinePrev_r <= dataSync_r[1];
        end
    end
    assign rxLine = dataSync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Baud generator: one tick per sample (async) or half bit (sync).

    logic baudRun, baudTick;
    logic [9:0] baudCnt_r, baudPeriod;

    assign baudRun = transmit_enable_r || rxCont_r || rxSingle_r; // RQ18
    always_comb begin
        if (syncSel_r) begin
            baudPeriod = {1'b0, baud_r, 1'b1}; // RQ24
        end else if (highSpeed_r) begin
            baudPeriod = {2'b00, baud_r}; // RQ24
        end else begin
            baudPeriod = {baud_r, 2'b11}; // RQ24
        end
    end
    assign baudTick = baudRun && baudCnt_r == 10'h000;

    // Held at zero while idle so the first tick comes immediately.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            baudCnt_r <= 10'h000;
        end else if (!baudRun) begin
            baudCnt_r <= 10'h000; // RQ18
        end else if (baudTick) begin
            baudCnt_r <= baudPeriod;
        end else begin
            baudCnt_r <= baudCnt_r - 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Asynchronous receiver.

    usrt_rxstate_e rxState_r;
    logic [3:0] smpCnt_r, bitCnt_r;
    logic [8:0] rxShift_r;
    logic rxOn, stopDone, fifoFull, overrun_r;
    logic [1:0] fifoCnt_r;
    logic fifoWrPtr_r, fifoRdPtr_r;
    usrt_rxword_s fifoMem_r [2];
    usrt_rxword_s fifoHead, rxWord;

    assign rxOn = portEn_r && rxCont_r && !syncSel_r; // RQ2
    assign stopDone = rxState_r == RX_STOP && baudTick &&
        smpCnt_r == RX_LAST_TICK;
    assign fifoFull = fifoCnt_r == 2'd2;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxState_r <= RX_IDLE;
            smpCnt_r <= 4'h0;
            bitCnt_r <= 4'h0;
            rxShift_r <= 9'h000;
        end else if (!rxOn) begin
            rxState_r <= RX_IDLE;
        end else begin
            if (baudTick) begin
                smpCnt_r <= smpCnt_r + 4'h1; // RQ1
            end
            case (rxState_r)
                RX_IDLE: begin
                    if (rxLinePrev_r && !rxLine) begin
                        rxState_r <= RX_START; // RQ25
                        smpCnt_r <= 4'h0;
                    end
                end
                RX_START: begin
                    if (baudTick && smpCnt_r == RX_MID_TICK) begin
                        smpCnt_r <= 4'h0;
                        bitCnt_r <= 4'h0;
                        // A glitch shorter than half a bit is dropped.
                        rxState_r <= rxLine ? RX_IDLE : RX_DATA; // RQ25
                    end
                end
                RX_DATA: begin
                    if (baudTick && smpCnt_r == RX_LAST_TICK) begin
                        // LSB first; a nine-bit frame fills the top bit.
                        rxShift_r <= {rxLine, rxShift_r[8:1]}; // RQ23
                        bitCnt_r <= bitCnt_r + 4'h1;
                        if (bitCnt_r == (rxNine_r ? 4'd8 : 4'd7)) begin
                            rxState_r <= RX_STOP; // RQ23
                        end
                    end
                end
                RX_STOP: begin
                    if (stopDone) begin
                        rxState_r <= RX_IDLE;
                    end
                end
                default: begin
                    rxState_r <= RX_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rxWord.frameErr = !rxLine; // RQ8
        if (rxNine_r) begin
            rxWord.data = rxShift_r[7:0];
            rxWord.ninth = rxShift_r[8];
        end else begin
            rxWord.data = rxShift_r[8:1];
            rxWord.ninth = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-deep receive FIFO holding data with its status bits.

    logic fifoPush, fifoPop;

    assign fifoPush = stopDone && !fifoFull && !overrun_r; // RQ3 RQ7
    assign fifoPop = rdRxBuf && fifoCnt_r != 2'd0; // RQ5
    assign fifoHead = fifoMem_r[fifoRdPtr_r]; // RQ9

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifoMem_r[0] <= '0;
            fifoMem_r[1] <= '0;
        end else if (fifoPush) begin
            fifoMem_r[fifoWrPtr_r] <= rxWord; // RQ9
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifoCnt_r <= 2'd0;
            fifoWrPtr_r <= 1'b0;
            fifoRdPtr_r <= 1'b0;
        end else begin
            if (fifoPush) begin
                fifoWrPtr_r <= !fifoWrPtr_r;
            end
            if (fifoPop) begin
                fifoRdPtr_r <= !fifoRdPtr_r; // RQ9
            end
            if (fifoPush && !fifoPop) begin
                fifoCnt_r <= fifoCnt_r + 2'd1;
            end else if (fifoPop && !fifoPush) begin
                fifoCnt_r <= fifoCnt_r - 2'd1; // RQ4
            end
        end
    end

    // The set term can only occur with continuous enable high.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            overrun_r <= 1'b0;
        end else if (stopDone && fifoFull) begin
            overrun_r <= 1'b1; // RQ6
        end else if (!rxCont_r) begin
            overrun_r <= 1'b0; // RQ7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronous master transmitter.

    logic masterMode, rxReq, txRun, txLoad;
    logic txBufFull_r, tsrBusy_r, clkLevel_r, dataLevel_r;
    logic [7:0] txBuf_r;
    logic [8:0] tsr_r;
    logic [3:0] bitsLeft_r;

    assign masterMode = syncSel_r && clkMaster_r && portEn_r; // RQ13 RQ14
    assign rxReq = rxCont_r || rxSingle_r;
    // Receive requests freeze the shifter without resetting it.
    assign txRun = masterMode && transmit_enable_r && !rxReq; // RQ12 RQ20
    assign txLoad = txRun && txBufFull_r && !tsrBusy_r; // RQ15

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txBuf_r <= 8'h00;
            txBufFull_r <= 1'b0;
        end else if (wrTxBuf) begin
            txBuf_r <= regWrData;
            txBufFull_r <= 1'b1; // RQ15
        end else if (txLoad) begin
            txBufFull_r <= 1'b0; // RQ15
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tsr_r <= 9'h000;
            tsrBusy_r <= 1'b0;
            bitsLeft_r <= 4'h0;
            clkLevel_r <= 1'b0;
            dataLevel_r <= 1'b0;
        end else if (!transmit_enable_r) begin
            tsrBusy_r <= 1'b0; // RQ19
            clkLevel_r <= 1'b0;
        end else if (txLoad) begin
            // Ninth bit is taken as it stands at this transfer.
            tsr_r <= {txNinth_r, txBuf_r}; // RQ22
            tsrBusy_r <= 1'b1;
            bitsLeft_r <= txNine_r ? 4'd9 : 4'd8;
        end else if (txRun && tsrBusy_r && baudTick) begin
            clkLevel_r <= !clkLevel_r;
            if (!clkLevel_r) begin
                dataLevel_r <= tsr_r[0]; // RQ17
                tsr_r <= {1'b0, tsr_r[8:1]};
                bitsLeft_r <= bitsLeft_r - 4'h1;
            end else if (bitsLeft_r == 4'h0) begin
                tsrBusy_r <= 1'b0; // RQ15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and read-back.

    assign clkPinOut = clkLevel_r;
    assign clkPinOe = masterMode && (transmit_enable_r || rxReq); // RQ14 RQ19 RQ20
    assign dataPinOut = dataLevel_r;
    assign dataPinOe = txRun; // RQ19 RQ20 RQ21

    logic [7:0] rdNext;
    always_comb begin
        rdNext = 8'h00;
        case (regAddr)
            OFS_RX_STATUS: begin
                rdNext[RX_PORT_EN_BIT] = portEn_r;
                rdNext[RX_NINE_SEL_BIT] = rxNine_r;
                rdNext[RX_SINGLE_BIT] = rxSingle_r;
                rdNext[RX_CONT_BIT] = rxCont_r;
                rdNext[RX_FRAME_ERR_BIT] = fifoHead.frameErr; // RQ9
                rdNext[RX_OVERRUN_BIT] = overrun_r;
                rdNext[RX_NINTH_BIT] = fifoHead.ninth; // RQ9
            end
            OFS_TX_STATUS: begin
                rdNext[TX_CLK_MASTER_BIT] = clkMaster_r;
                rdNext[TX_NINE_SEL_BIT] = txNine_r;
                rdNext[TX_ENABLE_BIT] = transmit_enable_r;
                rdNext[TX_SYNC_SEL_BIT] = syncSel_r;
                rdNext[TX_HIGH_SPEED_BIT] = highSpeed_r;
                rdNext[TX_SHIFT_EMPTY_BIT] = !tsrBusy_r; // RQ16
                rdNext[TX_NINTH_BIT] = txNinth_r;
            end
            OFS_IRQ_FLAGS: begin
                rdNext[FLAG_RX_BIT] = fifoCnt_r != 2'd0; // RQ3 RQ4
                rdNext[FLAG_TX_BIT] = transmit_enable_r && !txBufFull_r; // RQ15
            end
            OFS_RX_BUFFER: rdNext = fifoHead.data;
            OFS_TX_BUFFER: rdNext = txBuf_r;
            OFS_BAUD: rdNext = baud_r;
            OFS_IRQ_ENABLE: rdNext = irqEnable_r;
            OFS_IRQ_CONTROL: rdNext = irqControl_r;
            default: rdNext = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            regRdData <= rdNext;
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule

//--- usrt_core_properties.sv
// Concurrent checks on the pins and register port of the serial port.
`timescale 1ns/1ps
module usrt_core_properties
    import usrt_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    // Serial pins.
    input wire logic clkPinIn,
    input wire logic clkPinOut,
    input wire logic clkPinOe,
    input wire logic dataPinIn,
    input wire logic dataPinOut,
    input wire logic dataPinOe,
    input wire logic syncRxWordDone
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!arst_n);
////////////////////////////////////////////////////////////////////////////
// Shadows of the control bits; the word-done pulse clears the single
// receive bit in hardware, so the shadow follows it there too.
logic [7:0] txCfg_r;
logic [7:0] rxCfg_r;
logic transmit_enable;
logic rxOn;
logic master;
always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
        txCfg_r <= TX_STATUS_RESET;
    else if (regWrite && regAddr == OFS_TX_STATUS)
        txCfg_r <= regWrData;
end
always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
        rxCfg_r <= RX_STATUS_RESET;
    else if (regWrite && regAddr == OFS_RX_STATUS)
        rxCfg_r <= regWrData;
    else if (syncRxWordDone && txCfg_r[TX_SYNC_SEL_BIT])
        rxCfg_r[RX_SINGLE_BIT] <= 1'b0;
end
assign transmit_enable = txCfg_r[TX_ENABLE_BIT];
assign rxOn = rxCfg_r[RX_CONT_BIT] | rxCfg_r[RX_SINGLE_BIT];
assign master = txCfg_r[TX_SYNC_SEL_BIT] & txCfg_r[TX_CLK_MASTER_BIT]
    & rxCfg_r[RX_PORT_EN_BIT];
////////////////////////////////////////////////////////////////////////////
data_float_a: assert property (!transmit_enable |-> !dataPinOe)
    else $error("data pin driven with transmit off");
clk_float_a: assert property (!transmit_enable && !rxOn |-> !clkPinOe)
    else $error("clock pin driven with all enables clear");
rx_blocks_tx_a: assert property (rxOn |-> !dataPinOe)
    else $error("data pin driven while receiving");
clk_kept_a: assert property (master && transmit_enable && rxOn |-> clkPinOe)
    else $error("clock pin released during receive abort");
clk_still_a: assert property ((!transmit_enable && !rxOn) [*3] |->
    $stable(clkPinOut)) else $error("shift clock runs while held");
clk_start_a: assert property ($rose(transmit_enable) && master |->
    ##[1:8] clkPinOut) else $error("no shift clock after enable");
data_hold_a: assert property ($fell(clkPinOut) && dataPinOe |->
    $stable(dataPinOut) ##1 $stable(dataPinOut))
    else $error("data moved at falling clock");
overrun_error_clear_a: assert property (regRead && regAddr == OFS_RX_STATUS
    && !$past(rxCfg_r[RX_CONT_BIT]) |=> regRdData[RX_OVERRUN_BIT] == 1'b0)
    else $error("overrun seen with continuous receive off");
async_quiet_a: assert property (!master |->
    !clkPinOe && !dataPinOe) else $error("pins driven outside master");
tx_resume_a: assert property (syncRxWordDone && master && transmit_enable
    && rxCfg_r[RX_SINGLE_BIT] && !rxCfg_r[RX_CONT_BIT] |->
    ##[1:3] dataPinOe) else $error("transmit did not resume");
cover property ($fell(clkPinOut) && dataPinOe);
cover property (regRead && regAddr == OFS_RX_BUFFER);
cover property (syncRxWordDone && master && transmit_enable);
endmodule

//--- usrt_remote_node.sv
// Remote serial node: asynchronous sender and synchronous slave sampler.
`timescale 1ns/1ps
module usrt_remote_node #(
    parameter int BIT_NS = 160
) (
    // Line driven toward the receiver.
    output logic txLine,
    // Synchronous clock and data as seen on the wire.
    input wire logic clkLine,
    input wire logic dataLine,
    input wire logic dataDriven
);
    logic rxBits[$];
    initial txLine = 1'b1;
    // The stop level is a choice so that a framing error can be provoked.
    task automatic sendFrame(input logic [8:0] w, input int n,
                             input logic stopBit);
        txLine <= 1'b0;
        #(BIT_NS);
        for (int i = 0; i < n; i++) begin
            txLine <= w[i];
            #(BIT_NS);
        end
        txLine <= stopBit;
        #(BIT_NS);
        txLine <= 1'b1;
        #(2 * BIT_NS);
    endtask
    // Taken at the falling edge, where the master holds data stable.
    always @(negedge clkLine) begin
        if (dataDriven)
            rxBits.push_back(dataLine);
    end
endmodule

//--- tb.sv
// Self-checking testbench of the serial receiver and master transmitter.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    n_fail++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb;
    import usrt_pkg::*;
    logic sys_clk, arst_n, regWrite, regRead, syncRxWordDone;
    logic [7:0] regAddr, regWrData;
    wire logic [7:0] regRdData;
    wire logic clkPinIn, clkPinOut, clkPinOe, dataPinIn, dataPinOut;
    wire logic dataPinOe, nodeLine;
    int n_fail, checks;
    usrt_core u_usrt_core (.sys_clk(sys_clk), .arst_n(arst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .clkPinIn(clkPinIn),
        .clkPinOut(clkPinOut), .clkPinOe(clkPinOe), .dataPinIn(dataPinIn),
        .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
        .syncRxWordDone(syncRxWordDone));
    usrt_remote_node #(.BIT_NS(320)) u_usrt_remote_node (.txLine(nodeLine),
        .clkLine(clkPinIn), .dataLine(dataPinIn), .dataDriven(dataPinOe));
    // The clock line is pulled low when nobody drives it.
    assign clkPinIn = clkPinOe ? clkPinOut : 1'b0;
    assign dataPinIn = dataPinOe ? dataPinOut : nodeLine;
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] e,
                       input logic [7:0] m = 8'hFF);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        `CHK(regRdData & m, e)
    endtask
    task automatic send(input logic [8:0] w, input int n, input logic s);
        u_usrt_remote_node.sendFrame(w, n, s);
    endtask
    task automatic wait_bits(input int n);
        int k;
        for (k = 0; k < 4000; k++) begin
            if (u_usrt_remote_node.rxBits.size() >= n)
                break;
            @(posedge sys_clk);
        end
        if (k == 4000) begin
            n_fail++;
            $display("[ERR] %0t timeout on shift clock", $time);
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk(OFS_TX_STATUS, 8'h02);
        chk(OFS_RX_STATUS, 8'h00);
        chk(OFS_IRQ_FLAGS, 8'h00);
        chk(OFS_RX_BUFFER, 8'h00);
        chk(OFS_IRQ_ENABLE, 8'h00);
        chk(8'h40, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h30);
        chk(OFS_IRQ_ENABLE, 8'h30);
        wr(OFS_IRQ_FLAGS, 8'hFF);
        chk(OFS_IRQ_FLAGS, 8'h00);
        wr(OFS_TX_STATUS, 8'h00);
        chk(OFS_TX_STATUS, 8'h02);
        $display("test regs done");
    endtask
    task automatic t_async();
        wr(OFS_BAUD, 8'h03);
        wr(OFS_TX_STATUS, 8'h04);
        wr(OFS_RX_STATUS, 8'h80);
        send(9'h0A5, 8, 1'b1);
        chk(OFS_IRQ_FLAGS, 8'h00);
        wr(OFS_RX_STATUS, 8'hC0);
        wr(OFS_RX_STATUS, 8'hD0);
        send(9'h1A5, 9, 1'b1);
        chk(OFS_IRQ_FLAGS, 8'h20);
        chk(OFS_RX_STATUS, 8'hD1);
        chk(OFS_RX_BUFFER, 8'hA5);
        chk(OFS_IRQ_FLAGS, 8'h00);
        $display("test async receive done");
    endtask
    task automatic t_overrun();
        wr(OFS_BAUD, 8'h00);
        wr(OFS_TX_STATUS, 8'h00);
        wr(OFS_RX_STATUS, 8'h90);
        send(9'h011, 8, 1'b1);
        send(9'h022, 8, 1'b0);
        send(9'h033, 8, 1'b1);
        chk(OFS_RX_STATUS, 8'h92);
        chk(OFS_RX_BUFFER, 8'h11);
        chk(OFS_RX_STATUS, 8'h96);
        chk(OFS_RX_BUFFER, 8'h22);
        send(9'h044, 8, 1'b1);
        chk(OFS_IRQ_FLAGS, 8'h00);
        wr(OFS_RX_STATUS, 8'h80);
        chk(OFS_RX_STATUS, 8'h80, 8'hF2);
        wr(OFS_RX_STATUS, 8'h90);
        send(9'h055, 8, 1'b1);
        chk(OFS_RX_BUFFER, 8'h55);
        $display("test overrun done");
    endtask
    task automatic t_sync_tx();
        logic [17:0] e;
        e = {1'b1, 8'hC3, 1'b1, 8'h5A};
        wr(OFS_BAUD, 8'h00);
        wr(OFS_RX_STATUS, 8'h80);
        wr(OFS_TX_STATUS, 8'hD1);
        u_usrt_remote_node.rxBits.delete();
        wr(OFS_TX_BUFFER, 8'h5A);
        wr(OFS_TX_STATUS, 8'hF1);
        chk(OFS_IRQ_FLAGS, 8'h10);
        wr(OFS_TX_BUFFER, 8'hC3);
        chk(OFS_IRQ_FLAGS, 8'h00);
        chk(OFS_TX_STATUS, 8'hF1);
        wait_bits(18);
        for (int i = 0; i < 18; i++)
            `CHK(u_usrt_remote_node.rxBits[i], e[i])
        repeat (4) @(posedge sys_clk);
        chk(OFS_TX_STATUS, 8'hF3);
        $display("test sync transmit done");
    endtask
    task automatic t_abort();
        wr(OFS_TX_STATUS, 8'h90);
        u_usrt_remote_node.rxBits.delete();
        wr(OFS_TX_BUFFER, 8'h96);
        wr(OFS_TX_STATUS, 8'hB0);
        wait_bits(3);
        wr(OFS_RX_STATUS, 8'hA0);
        #1;
        `CHK(dataPinOe, 1'b0)
        `CHK(clkPinOe, 1'b1)
        @(posedge sys_clk);
        syncRxWordDone <= 1'b1;
        @(posedge sys_clk);
        syncRxWordDone <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(dataPinOe, 1'b1)
        chk(OFS_RX_STATUS, 8'h80, 8'hF0);
        wr(OFS_TX_STATUS, 8'h90);
        #1;
        `CHK(dataPinOe, 1'b0)
        `CHK(clkPinOe, 1'b0)
        chk(OFS_TX_STATUS, 8'h92);
        $display("test abort done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        arst_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        syncRxWordDone = 1'b0;
        n_fail = 0;
        checks = 0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_async();
        t_overrun();
        t_sync_tx();
        t_abort();
        report_and_stop();
    end
endmodule
bind usrt_core usrt_core_properties u_usrt_core_properties (
    .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .clkPinIn(clkPinIn), .clkPinOut(clkPinOut),
    .clkPinOe(clkPinOe), .dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
    .dataPinOe(dataPinOe), .syncRxWordDone(syncRxWordDone));
